// [ulic_pkg.sv]
package ulic_pkg;
  // register word offsets on the wishbone bus (byte addresses)
  localparam logic [4:0] ADDR_ISS  = 5'h00; // interrupt_source_status (ro)
  localparam logic [4:0] ADDR_LFC  = 5'h04; // line_format_control
  localparam logic [4:0] ADDR_MLC  = 5'h08; // modem_line_control
  localparam logic [4:0] ADDR_CFG  = 5'h0C; // fifo/feature configuration
  localparam logic [4:0] ADDR_EVT  = 5'h10; // event injection (wo)
  localparam logic [4:0] ADDR_STAT = 5'h14; // derived status (ro)
  localparam logic [4:0] ADDR_UTRG = 5'h18; // user receive trigger level
  // line format field positions
  localparam int LF_PEN = 3;
  localparam int LF_EPS = 4;
  localparam int LF_STK = 5;
  localparam int LF_BRK = 6;
  localparam int LF_DLAB = 7;
  // modem control field positions
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_XANY = 5;
  // configuration field positions
  localparam int CF_FEN = 0;
  localparam int CF_TRG_LO = 6;
  localparam int CF_TBL_LO = 4;
  localparam int CF_EFEN = 8;
  localparam int CF_ARTS = 9;
  // event bits
  localparam int EV_LS = 0;
  localparam int EV_RXT = 1;
  localparam int EV_TO = 2;
  localparam int EV_TX = 3;
  localparam int EV_MS = 4;
  localparam int EV_XOFF = 5;
  localparam int EV_CR = 6;
  localparam int EV_XON = 7;
  localparam int EV_N = 8;
  // interrupt source codes on bits 5:0
  localparam logic [5:0] IC_NONE = 6'h01;
  localparam logic [5:0] IC_LS   = 6'h06;
  localparam logic [5:0] IC_RXT  = 6'h04;
  localparam logic [5:0] IC_TO   = 6'h0C;
  localparam logic [5:0] IC_TX   = 6'h02;
  localparam logic [5:0] IC_MS   = 6'h00;
  localparam logic [5:0] IC_XOFF = 6'h10;
  localparam logic [5:0] IC_CR   = 6'h20;
  localparam logic [1:0] FIFO_ON = 2'h3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] UTRG_RST   = 8'h01;
  // trigger table selector values
  typedef enum logic [1:0] {
    ULIC_TBL_A = 2'b00,
    ULIC_TBL_B = 2'b01,
    ULIC_TBL_C = 2'b10,
    ULIC_TBL_D = 2'b11
  } ulic_tbl_e;
endpackage : ulic_pkg

// [ulic_core.sv]
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
// Contract
// - rx trigger code picks level from table
// - feature bits choose among four trigger tables
// - source read reports and clears highest only
// - codes for line status, rx, timeout, tx
// - codes for modem, xoff, cts/rts change
// - bit0 low while pending, high otherwise
// - bits 4,5 need enhanced enable; xoff sticks
// - bits 7:6 show fifo enable
// - word length 5 to 8 bits
// - stop bits one, one-half, or two
// - parity enable for tx and rx
// - odd or even parity select
// - forced parity one or zero
// - break holds tx output low
// - bit7 redirects to divisor latch access
// - dtr pin low when bit set
// - rts pin low when set, auto option
// - out1 feeds ring indicate in loop
// - out2 drives irq enable or cd
// - loop-back enable bit
// - xon-any resumes on any character
// - ring status follows out1 in loop
module ulic_core
  import ulic_pkg::*;
(
  input  wire logic        clk,           // 25 MHz system clock
  input  wire logic        rst,           // synchronous, active high
  input  wire logic [4:0]  wb_adr_i,      // byte address
  input  wire logic [31:0] wb_dat_i,      // write data
  output logic      [31:0] wb_dat_o,      // read data, registered
  input  wire logic [3:0]  wb_sel_i,      // byte enables
  input  wire logic        wb_we_i,       // write strobe
  input  wire logic        wb_cyc_i,      // cycle valid
  input  wire logic        wb_stb_i,      // strobe
  output logic             wb_ack_o,      // one-cycle acknowledge
  input  wire logic [6:0]  rx_fifo_level, // characters in rx fifo
  input  wire logic        rx_char_in,    // pulse: character received
  input  wire logic        ring_n_pin,    // external ring indicate, low act
  input  wire logic        cd_n_pin,      // external carrier detect, low act
  input  wire logic        auto_rts_n,    // flow-control rts, low act
  input  wire logic        tx_serial_in,  // serializer output before break
  output logic             tx_pin,        // serial line out
  output logic             dtr_n,         // data terminal ready, low act
  output logic             rts_n,         // request to send, low act
  output logic             irq_o,         // interrupt value
  output logic             irq_oe_n,      // irq enable, low = driving
  output logic [3:0]       word_bits,     // 5..8
  output logic             stop_half,     // 1.5 stop bits
  output logic             stop_two,      // 2 stop bits
  output logic             parity_en,     // parity bit present
  output logic             parity_odd,    // odd parity
  output logic             parity_force,  // parity stuck
  output logic             parity_value,  // stuck value
  output logic             divisor_sel,   // divisor latch mapped
  output logic             loop_en,       // loop-back active
  output logic             ring_status,   // ring indicate status bit
  output logic             cd_status,     // carrier detect status bit
  output logic             xoff_hold,     // transmit paused by xoff
  output logic             rx_trig_hit    // rx fifo at trigger
);

  logic [7:0]         lfc_r;       // line_format_control
  logic [7:0]         mlc_r;       // modem_line_control
  logic [9:0]         cfg_r;       // fifo enable, trigger code, table, feats
  logic [7:0]         utrg_r;      // user-programmed trigger level
  logic [EV_N-1:0]    pend_r;      // sticky pending sources
  logic [EV_N-1:0]    pend_nxt;
  logic               xoff_r;      // xoff seen, awaiting xon
  logic [5:0]         top_code;    // highest pending code
  logic [EV_N-1:0]    top_mask;    // bit that the read clears
  logic [6:0]         trig_lvl;    // selected rx trigger level
  logic               acc;         // new access this cycle
  logic               rd_iss;      // read of interrupt source
  logic               wr;          // write access
  logic [7:0]         evt_set;     // events injected by software

  // trigger lookup: table by feature bits, level by code
  function automatic logic [6:0] trig_of(input logic [1:0] tbl,
                                          input logic [1:0] code,
                                          input logic [7:0] user);
    logic [6:0] l;
    l = 7'h01;
    case (ulic_tbl_e'(tbl))
      ULIC_TBL_A: case (code)
        2'b00: l = 7'h01;
        2'b01: l = 7'h04;
        2'b10: l = 7'h08;
        default: l = 7'h0E;
      endcase
      ULIC_TBL_B: case (code)
        2'b00: l = 7'h08;
        2'b01: l = 7'h10;
        2'b10: l = 7'h18;
        default: l = 7'h1C;
      endcase
      ULIC_TBL_C: case (code)
        2'b00: l = 7'h08;
        2'b01: l = 7'h10;
        2'b10: l = 7'h38;
        default: l = 7'h3C;
      endcase
      default: l = user[6:0]; // table d: user level
    endcase
    return l;
  endfunction : trig_of

  // byte-lane merge for a register write
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] s);
    return s[0] ? d[7:0] : old;
  endfunction : lane0

  // bus decode; ack low between beats so each access is counted once
  assign acc    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr     = acc && wb_we_i;
  assign rd_iss = acc && !wb_we_i && (wb_adr_i == ADDR_ISS);
  assign evt_set = (wr && wb_adr_i == ADDR_EVT && wb_sel_i[0])
                   ? wb_dat_i[7:0] : RESET_BYTE;

  // selected trigger level and compare
  assign trig_lvl = trig_of(cfg_r[CF_TBL_LO +: 2],
                            cfg_r[CF_TRG_LO +: 2], utrg_r);
  assign rx_trig_hit = cfg_r[CF_FEN] && (rx_fifo_level >= trig_lvl);

  // priority encoder over pending sources
  always_comb begin
    top_code = IC_NONE;
    top_mask = '0;
    if (pend_r[EV_LS]) begin
      top_code = IC_LS;
      top_mask[EV_LS] = 1'b1;
    end else if (pend_r[EV_RXT]) begin
      top_code = IC_RXT;
      top_mask[EV_RXT] = 1'b1;
    end else if (pend_r[EV_TO]) begin // below rx data, above tx
      top_code = IC_TO;
      top_mask[EV_TO] = 1'b1;
    end else if (pend_r[EV_TX]) begin
      top_code = IC_TX;
      top_mask[EV_TX] = 1'b1;
    end else if (pend_r[EV_MS]) begin
      top_code = IC_MS;
      top_mask[EV_MS] = 1'b1;
    // xoff stays visible until xon clears the hold, even after a read
    end else if ((pend_r[EV_XOFF] || xoff_r) && cfg_r[CF_EFEN]) begin
      top_code = IC_XOFF;
      top_mask[EV_XOFF] = 1'b1;
    end else if (pend_r[EV_CR] && cfg_r[CF_EFEN]) begin
      top_code = IC_CR;
      top_mask[EV_CR] = 1'b1;
    end
  end

  // pending update: new events win over the read clear
  always_comb begin
    pend_nxt = pend_r;
    if (rd_iss) begin
      pend_nxt = pend_r & ~top_mask;
    end
    pend_nxt[EV_XON] = 1'b0; // xon is a pulse, never pending
    if (rx_trig_hit) begin
      pend_nxt[EV_RXT] = 1'b1;
    end
    pend_nxt = pend_nxt | (evt_set & ~(8'h1 << EV_XON));
  end

  // pending source register
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // xoff hold: set on xoff, cleared by xon or any char under xon-any
  always_ff @(posedge clk) begin
    if (rst) begin
      xoff_r <= 1'b0;
    end else if (evt_set[EV_XOFF]) begin
      xoff_r <= 1'b1;
    end else if (evt_set[EV_XON]) begin
      xoff_r <= 1'b0;
    end else if (mlc_r[MC_XANY] && rx_char_in) begin
      xoff_r <= 1'b0;
    end
  end

  // control register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      lfc_r  <= RESET_BYTE;
      mlc_r  <= RESET_BYTE;
      cfg_r  <= '0;
      utrg_r <= UTRG_RST;
    end else if (wr) begin
      case (wb_adr_i)
        ADDR_LFC: lfc_r <= lane0(lfc_r, wb_dat_i, wb_sel_i);
        ADDR_MLC: mlc_r <= lane0(mlc_r, wb_dat_i, wb_sel_i);
        ADDR_UTRG: utrg_r <= lane0(utrg_r, wb_dat_i, wb_sel_i);
        ADDR_CFG: begin
          cfg_r[7:0] <= lane0(cfg_r[7:0], wb_dat_i, wb_sel_i);
          if (wb_sel_i[1]) begin
            cfg_r[9:8] <= wb_dat_i[9:8];
          end
        end
        default: ; // other offsets hold nothing writable
      endcase
    end
  end

  // bus answer: one wait-free cycle, unmapped reads return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        case (wb_adr_i)
          ADDR_ISS: wb_dat_o <= {24'h0,
                      cfg_r[CF_FEN] ? FIFO_ON : 2'h0, top_code};
          ADDR_LFC: wb_dat_o <= {24'h0, lfc_r};
          ADDR_MLC: wb_dat_o <= {24'h0, mlc_r};
          ADDR_CFG: wb_dat_o <= {22'h0, cfg_r};
          ADDR_UTRG: wb_dat_o <= {24'h0, utrg_r};
          ADDR_STAT: wb_dat_o <= {24'h0, trig_lvl[6:0], xoff_r};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // line format decode
  assign word_bits    = 4'h5 + {2'b00, lfc_r[1:0]};
  assign stop_half    = lfc_r[2] && (lfc_r[1:0] == 2'b00);
  assign stop_two     = lfc_r[2] && (lfc_r[1:0] != 2'b00);
  assign parity_en    = lfc_r[LF_PEN];
  assign parity_odd   = !lfc_r[LF_EPS];
  assign parity_force = lfc_r[LF_PEN] && lfc_r[LF_STK];
  assign parity_value = !lfc_r[LF_EPS];
  assign divisor_sel  = lfc_r[LF_DLAB];
  assign tx_pin       = lfc_r[LF_BRK] ? 1'b0 : tx_serial_in;

  // modem pins; outputs follow the control bits in loop too
  assign loop_en   = mlc_r[MC_LOOP];
  assign dtr_n     = !mlc_r[MC_DTR];
  assign rts_n     = cfg_r[CF_ARTS] ? auto_rts_n : !mlc_r[MC_RTS];
  assign ring_status = loop_en ? mlc_r[MC_OUT1] : !ring_n_pin;
  assign cd_status   = loop_en ? mlc_r[MC_OUT2] : !cd_n_pin;
  assign irq_oe_n  = !mlc_r[MC_OUT2];
  assign irq_o     = (top_code != IC_NONE);
  assign xoff_hold = xoff_r;

endmodule : ulic_core

// [ulic_assertions.sv]
`timescale 1ns/1ps
// pin-level checks; register writes are seen as bus beats
module ulic_checker
  import ulic_pkg::*;
(
  input logic        clk,
  input logic        rst,
  input logic [4:0]  wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic [3:0]  wb_sel_i,
  input logic        wb_we_i,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_ack_o,
  input logic        tx_serial_in,
  input logic        tx_pin,
  input logic        dtr_n,
  input logic        irq_oe_n,
  input logic [3:0]  word_bits,
  input logic        stop_half,
  input logic        loop_en,
  input logic        ring_status,
  input logic        ring_n_pin,
  input logic        cd_status,
  input logic        cd_n_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // lane-0 write to modem control taken at this edge
  wire mlc_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                && wb_sel_i[0] && wb_adr_i == ADDR_MLC;
  word_len_a: assert property (word_bits inside {[4'h5:4'h8]})
    else $error("word length out of range");
  half_stop_a: assert property (stop_half |-> word_bits == 4'h5)
    else $error("half stop without five bit words");
  line_break_a: assert property (tx_pin |-> tx_serial_in)
    else $error("tx high while serializer low");
  ring_pin_a: assert property (!loop_en |-> ring_status != ring_n_pin)
    else $error("ring status not pin complement");
  cd_pin_a: assert property (!loop_en |-> cd_status != cd_n_pin)
    else $error("carrier status not pin complement");
  reset_pins_a: assert property ($past(rst) |-> dtr_n && irq_oe_n && !loop_en)
    else $error("modem pins not idle after reset");
  dtr_write_a: assert property (mlc_wr |=> dtr_n == !$past(wb_dat_i[0]))
    else $error("dtr pin does not follow write");
  loop_write_a: assert property (mlc_wr |=> loop_en == $past(wb_dat_i[4])
    && irq_oe_n == !$past(wb_dat_i[3])) else $error("loop or irq enable wrong");
endmodule : ulic_checker

// [ulic_modem.sv]
`timescale 1ns/1ps
// far-end modem: raises carrier DLY cycles after terminal ready
module ulic_modem #(
  parameter int DLY = 3 // answer delay, 0 answers at once
) (
  input  logic clk,
  input  logic dtr_n,
  input  logic ring_req,
  output logic ring_n_pin,
  output logic cd_n_pin
);
  int cnt = 0; // cycles since terminal ready went active
  assign ring_n_pin = !ring_req;
  assign cd_n_pin   = dtr_n || cnt < DLY;
  // count restarts whenever the terminal drops ready
  always @(posedge clk) cnt <= dtr_n ? 0 : cnt + 1;
endmodule : ulic_modem

// [ulic_tb.sv]
`timescale 1ns/1ps
module testbench;
  import ulic_pkg::*;
  logic        clk = 1'h0, rst = 1'h1;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd; // rd: last read data
  logic [3:0]  wb_sel_i = 4'h0, word_bits;
  logic        wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_ack_o;
  logic [6:0]  rx_fifo_level = 7'h00, u, l;
  logic        rx_char_in = 1'h0, auto_rts_n = 1'h1, tx_serial_in = 1'h0;
  logic        ring_req = 1'h0, ring_n_pin, cd_n_pin, tx_pin, dtr_n, rts_n;
  logic        irq_o, irq_oe_n, stop_half, stop_two, parity_en, parity_odd;
  logic        parity_force, parity_value, divisor_sel, loop_en, ring_status;
  logic        cd_status, xoff_hold, rx_trig_hit;
  logic [7:0]  v;
  int          n_fail = 0, checks = 0;
  logic [5:0]  ic [5] = '{IC_LS, IC_RXT, IC_TX, IC_MS, IC_CR}; // by priority
  logic [7:0]  ev [4] = '{8'h04, 8'h20, 8'h00, 8'h80}; // timeout, xoff, -, xon
  logic [5:0]  ex [4] = '{IC_TO, IC_XOFF, IC_XOFF, IC_NONE};
  ulic_core u_ulic_core (.clk, .rst, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_fifo_level,
    .rx_char_in, .ring_n_pin, .cd_n_pin, .auto_rts_n, .tx_serial_in, .tx_pin,
    .dtr_n, .rts_n, .irq_o, .irq_oe_n, .word_bits, .stop_half, .stop_two,
    .parity_en, .parity_odd, .parity_force, .parity_value, .divisor_sel,
    .loop_en, .ring_status, .cd_status, .xoff_hold, .rx_trig_hit);
  ulic_modem #(.DLY(3)) u_ulic_modem (.clk, .dtr_n, .ring_req, .ring_n_pin,
    .cd_n_pin);
  initial forever #20 clk = ~clk;
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one classic cycle; held until ack is sampled high at an edge
  task automatic wb(logic [4:0] a, logic w, logic [31:0] d, logic [3:0] s = 4'h1);
    @(posedge clk);
    {wb_adr_i, wb_we_i, wb_dat_i, wb_sel_i} <= {a, w, d, s};
    {wb_cyc_i, wb_stb_i} <= 2'h3;
    do @(posedge clk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask : wb
  // receive trigger level for table t and code c
  function automatic logic [6:0] trig_exp(int t, int c, logic [6:0] usr);
    logic [6:0] lv [3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};
    return t == 3 ? usr : lv[t][c];
  endfunction : trig_exp
  task automatic give_verdict;
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    void'($urandom(97333));
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    wb(ADDR_ISS, 0, 0);
    chk("iss", rd[7:0], 8'h01);
    wb(ADDR_LFC, 0, 0);
    chk("lfc", rd[7:0], 8'h00);
    wb(5'h1C, 0, 0);
    chk("unmapped", rd, 32'h0);
    chk("rts", rts_n, 1'h1);
    // line format: break corner first, then random codes
    for (int i = 0; i < 16; i++) begin
      v = i == 0 ? 8'h44 : 8'($urandom);
      tx_serial_in <= 1'($urandom) | (i == 0);
      wb(ADDR_LFC, 1, v);
      wb(ADDR_LFC, 0, 0);
      chk("lfc", rd[7:0], v);
      chk("word", word_bits, 4'h5 + v[1:0]);
      chk("stop", {stop_half, stop_two}, {v[2] && !v[1:0], v[2] && v[1:0]});
      chk("par", {parity_en, parity_force}, {v[3], v[3] & v[5]});
      if (v[3] && !v[5]) chk("odd", parity_odd, !v[4]);
      if (v[3] && v[5]) chk("pval", parity_value, !v[4]);
      chk("brk", tx_pin, tx_serial_in & !v[6]);
      chk("dlab", divisor_sel, v[7]);
    end
    wb(ADDR_LFC, 1, 0);
    // modem control with random ring from the far end
    for (int i = 0; i < 16; i++) begin
      v = 8'($urandom) & 8'h3F;
      ring_req <= 1'($urandom);
      wb(ADDR_MLC, 1, v);
      wb(ADDR_MLC, 0, 0);
      chk("mlc", rd[5:0], v[5:0]);
      chk("dtr", {dtr_n, rts_n, irq_oe_n}, {!v[0], !v[1], !v[3]});
      chk("loop", loop_en, v[4]);
      chk("ring", ring_status, v[4] ? v[2] : ring_req);
      chk("cd", cd_status, v[4] ? v[3] : !cd_n_pin);
    end
    wb(ADDR_CFG, 1, 32'h101, 4'h3); // fifos and enhanced on
    wb(ADDR_EVT, 1, 32'h5B);
    chk("irq", irq_o, 1'h1);
    foreach (ic[k]) begin
      wb(ADDR_ISS, 0, 0);
      chk("iss", rd[7:0], {FIFO_ON, ic[k]});
    end
    foreach (ev[k]) begin
      wb(ADDR_EVT, 1, ev[k]);
      wb(ADDR_ISS, 0, 0);
      chk("iss", rd[7:0], {FIFO_ON, ex[k]});
    end
    wb(ADDR_CFG, 1, 32'h001, 4'h3); // enhanced off hides cts/rts source
    wb(ADDR_EVT, 1, 32'h40);
    wb(ADDR_ISS, 0, 0);
    chk("iss", rd[7:0], {FIFO_ON, IC_NONE});
    u = 7'(1 + $urandom % 100);
    wb(ADDR_UTRG, 1, u);
    // each table and code, one below and at the level
    for (int t = 0; t < 4; t++) for (int c = 0; c < 4; c++) begin
      l = trig_exp(t, c, u);
      wb(ADDR_CFG, 1, 32'(1 | t << 4 | c << 6));
      rx_fifo_level <= l - 7'h1;
      @(posedge clk) #1 chk("trig", rx_trig_hit, 1'h0);
      rx_fifo_level <= l;
      @(posedge clk) #1 chk("trig", rx_trig_hit, 1'h1);
    end
    give_verdict();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule : testbench
bind ulic_core ulic_checker u_ulic_checker (.clk, .rst, .wb_adr_i, .wb_dat_i,
  .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tx_serial_in, .tx_pin,
  .dtr_n, .irq_oe_n, .word_bits, .stop_half, .loop_en, .ring_status,
  .ring_n_pin, .cd_status, .cd_n_pin);
